//--- src/dsrp_pkg.sv
`default_nettype none

package dsrp_pkg;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int MCLK_PERIOD_NS = 100;
   localparam int DETECT_TIME_NS = 1000000;
   // least time: round up
   localparam int DETECT_CYCLES  = (DETECT_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam int INT_SEQ_NS     = 500;
   // longest time: round down, low phase takes under half the sequence
   localparam int INT_LOW_CYCLES = (INT_SEQ_NS / MCLK_PERIOD_NS) / 2;
   localparam int DET_W          = 16;

   // ----------------------------------------
   // frame layout and reset values
   // ----------------------------------------
   localparam int BYTE_BITS    = 8;
   localparam int ADDR_W       = 8;
   localparam int DATA_W       = 8;
   localparam int RW_BIT       = 7;
   localparam int IDX_HI_BIT   = 7;
   localparam logic INT_RESET  = 1'b1;
   localparam logic [6:0] SLAVE_ADDR_00 = 7'h1e;
   localparam logic [6:0] SLAVE_ADDR_01 = 7'h1d;
   localparam logic [6:0] SLAVE_ADDR_10 = 7'h1c;
   localparam logic [6:0] SLAVE_ADDR_11 = 7'h1f;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef struct packed {
      logic scl;
      logic sda;
      logic sel_hi;
      logic sel_lo;
   } dsrp_pins_t;

   typedef enum logic [2:0] {
      I_IDLE  = 3'h0,
      I_RX    = 3'h1,
      I_RXACK = 3'h3,
      I_TX    = 3'h2,
      I_TXACK = 3'h6,
      I_TXLD  = 3'h7
   } dsrp_i2c_st_t;

   typedef enum logic [1:0] {
      K_ADDR = 2'h0,
      K_IDX  = 2'h1,
      K_DATA = 2'h3
   } dsrp_kind_t;

   typedef enum logic [1:0] {
      D_PROBE_HI = 2'h0,
      D_PROBE_LO = 2'h1,
      D_INT_LOW  = 2'h3,
      D_RUN      = 2'h2
   } dsrp_det_st_t;

   typedef struct packed {
      dsrp_i2c_st_t      st;
      dsrp_kind_t        kind;
      logic [3:0]        cnt;
      logic [7:0]        sr;
      logic [ADDR_W-1:0] ptr;
      logic              oe;
   } dsrp_i2c_t;

   typedef struct packed {
      logic [2:0]        cnt;
      logic [1:0]        nbyte;
      logic              rw;
      logic [7:0]        sr;
      logic [ADDR_W-1:0] ptr;
      logic [7:0]        tx;
      logic [2:0]        txc;
      logic              miso;
   } dsrp_spi_t;

   typedef struct packed {
      dsrp_det_st_t      st;
      logic [DET_W-1:0]  cnt;
      logic              hi_seen;
      logic              four_wire;
      logic              intr;
   } dsrp_det_t;

   localparam dsrp_i2c_t I2C_RESET = '0;
   localparam dsrp_spi_t SPI_RESET = '0;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [6:0] dsrp_slave_addr(input logic hi, input logic lo);
      case ({hi, lo})
         2'b00:   dsrp_slave_addr = SLAVE_ADDR_00;
         2'b01:   dsrp_slave_addr = SLAVE_ADDR_01;
         2'b10:   dsrp_slave_addr = SLAVE_ADDR_10;
         default: dsrp_slave_addr = SLAVE_ADDR_11;
      endcase
   endfunction

endpackage

`default_nettype wire

//--- src/dsrp_sync.sv
`timescale 1ns/100ps
`default_nettype none

module dsrp_sync #(
   parameter int WIDTH = 4
) (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             rst,
   // levels
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;

endmodule

`default_nettype wire

//--- src/dsrp_regfile.sv
`timescale 1ns/100ps
`default_nettype none

module dsrp_regfile #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   // clock
   input  wire logic          mclk,
   // write port
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [DW-1:0] wr_data,
   // read port
   input  wire logic [AW-1:0] rd_addr,
   output var  logic [DW-1:0] rd_data
);

   // register contents belong to the rest of the sensor; held here as plain storage
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge mclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   assign rd_data = mem[rd_addr];

endmodule

`default_nettype wire

//--- src/dsrp_top.sv
`timescale 1ns/100ps
`default_nettype none

module dsrp_top
   import dsrp_pkg::*;
#(
   parameter int DETECT_LEN = dsrp_pkg::DETECT_CYCLES,
   parameter int AW         = dsrp_pkg::ADDR_W,
   parameter int DW         = dsrp_pkg::DATA_W
) (
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst,
   // shared clock pin: two-wire clock or four-wire clock
   input  wire logic scl_pin,
   // shared data pin: two-wire data or four-wire input
   input  wire logic sda_pin_in,
   output var  logic sda_pin_out,
   output var  logic sda_pin_oe,
   // high select pin: address bit or active-low transaction select
   input  wire logic address_select_high_bit,
   // low select pin: address bit or four-wire output
   input  wire logic address_select_low_bit_in,
   output var  logic address_select_low_bit_out,
   output var  logic address_select_low_bit_oe,
   // weak probe used only while detecting the mode
   output var  logic probe_level,
   output var  logic probe_en,
   // status
   output var  logic first_interrupt_output,
   output var  logic four_wire_mode,
   output var  logic detect_done
);

   // ----------------------------------------
   // pin synchronisers and edges
   // ----------------------------------------
   localparam logic [DET_W-1:0] DET_LEN   = DET_W'(DETECT_LEN);
   localparam logic [DET_W-1:0] DET_HALF  = DET_W'(DETECT_LEN / 2);
   localparam logic [DET_W-1:0] INT_LOW   = DET_W'(INT_LOW_CYCLES);

   dsrp_pins_t pins_raw;
   dsrp_pins_t s;
   dsrp_pins_t p_q;
   dsrp_pins_t p_d;

   assign pins_raw = '{scl: scl_pin, sda: sda_pin_in,
                       sel_hi: address_select_high_bit, sel_lo: address_select_low_bit_in};

   dsrp_sync #(
      .WIDTH ($bits(dsrp_pins_t))
   ) u_sync (
      .mclk     (mclk),
      .rst      (rst),
      .async_in (pins_raw),
      .sync_out (s)
   );

   always_comb begin
      p_d = s;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         p_q <= '0;
      end else begin
         p_q <= p_d;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic i2c_start;
   logic i2c_stop;

   assign scl_rise  = s.scl & ~p_q.scl;
   assign scl_fall  = ~s.scl & p_q.scl;
   assign i2c_start = s.scl & p_q.scl & p_q.sda & ~s.sda;
   assign i2c_stop  = s.scl & p_q.scl & ~p_q.sda & s.sda;

   // ----------------------------------------
   // mode detection and reset completion
   // ----------------------------------------
   dsrp_det_t det_q;
   dsrp_det_t det_d;

   always_comb begin
      det_d = det_q;
      case (det_q.st)
         D_PROBE_HI: begin
            det_d.cnt = det_q.cnt + 1'b1;
            if (det_q.cnt == DET_HALF - 1'b1) begin
               det_d.hi_seen = s.sel_lo;
               det_d.st      = D_PROBE_LO;
            end
         end
         D_PROBE_LO: begin
            det_d.cnt = det_q.cnt + 1'b1;
            if (det_q.cnt >= DET_LEN - 1'b1) begin
               det_d.four_wire = det_q.hi_seen & ~s.sel_lo;
               det_d.st        = D_INT_LOW;
               det_d.cnt       = '0;
               det_d.intr      = 1'b0;
            end
         end
         D_INT_LOW: begin
            det_d.cnt = det_q.cnt + 1'b1;
            if (det_q.cnt >= INT_LOW - 1'b1) begin
               det_d.intr = 1'b1;
               det_d.st   = D_RUN;
            end
         end
         D_RUN: begin
            det_d = det_q;
         end
         default: det_d.st = D_PROBE_HI;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         det_q <= '{st: D_PROBE_HI, cnt: '0, hi_seen: 1'b0, four_wire: 1'b0, intr: INT_RESET};
      end else begin
         det_q <= det_d;
      end
   end

   logic running;
   logic i2c_go;
   logic spi_go;

   assign running = (det_q.st == D_RUN);
   assign i2c_go  = running & ~det_q.four_wire;
   assign spi_go  = running & det_q.four_wire;

   // ----------------------------------------
   // register storage
   // ----------------------------------------
   logic          wr_en;
   logic [AW-1:0] wr_addr;
   logic [DW-1:0] wr_data;
   logic [AW-1:0] rd_addr;
   logic [DW-1:0] rd_data;
   logic          i2c_wr;
   logic          spi_wr;

   dsrp_regfile #(
      .AW (AW),
      .DW (DW)
   ) u_regs (
      .mclk    (mclk),
      .wr_en   (wr_en),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .rd_addr (rd_addr),
      .rd_data (rd_data)
   );

   // ----------------------------------------
   // two-wire slave
   // ----------------------------------------
   dsrp_i2c_t i_q;
   dsrp_i2c_t i_d;

   always_comb begin
      i_d    = i_q;
      i2c_wr = 1'b0;
      if (!i2c_go) begin
         i_d = I2C_RESET;
      end else if (i2c_start) begin
         i_d.st   = I_RX;
         i_d.kind = K_ADDR;
         i_d.cnt  = '0;
         i_d.oe   = 1'b0;
      end else if (i2c_stop) begin
         i_d.st = I_IDLE;
         i_d.oe = 1'b0;
      end else begin
         case (i_q.st)
            I_RX: begin
               if (scl_rise) begin
                  i_d.sr  = {i_q.sr[6:0], s.sda};
                  i_d.cnt = i_q.cnt + 1'b1;
               end else if (scl_fall && i_q.cnt == 4'(BYTE_BITS)) begin
                  if (i_q.kind == K_ADDR && i_q.sr[7:1] != dsrp_slave_addr(s.sel_hi, s.sel_lo)) begin
                     i_d.st = I_IDLE;
                  end else begin
                     i_d.st = I_RXACK;
                     i_d.oe = 1'b1;
                  end
               end
            end
            I_RXACK: begin
               if (scl_fall) begin
                  i_d.oe  = 1'b0;
                  i_d.cnt = '0;
                  i_d.st  = I_RX;
                  case (i_q.kind)
                     K_ADDR: begin
                        if (i_q.sr[0]) begin
                           i_d.st  = I_TX;
                           i_d.oe  = ~rd_data[7];
                           i_d.sr  = {rd_data[6:0], 1'b0};
                           i_d.cnt = 4'h1;
                        end else begin
                           i_d.kind = K_IDX;
                        end
                     end
                     K_IDX: begin
                        i_d.ptr  = i_q.sr;
                        i_d.kind = K_DATA;
                     end
                     default: begin
                        i2c_wr  = 1'b1;
                        i_d.ptr = i_q.ptr + 1'b1;
                     end
                  endcase
               end
            end
            I_TX: begin
               if (scl_fall) begin
                  if (i_q.cnt == 4'(BYTE_BITS)) begin
                     i_d.st = I_TXACK;
                     i_d.oe = 1'b0;
                  end else begin
                     i_d.oe  = ~i_q.sr[7];
                     i_d.sr  = {i_q.sr[6:0], 1'b0};
                     i_d.cnt = i_q.cnt + 1'b1;
                  end
               end
            end
            I_TXACK: begin
               if (scl_rise) begin
                  // advance on ack, stop sending on nack
                  if (s.sda) begin
                     i_d.st = I_IDLE;
                  end else begin
                     i_d.ptr = i_q.ptr + 1'b1;
                     i_d.st  = I_TXLD;
                  end
               end
            end
            I_TXLD: begin
               if (scl_fall) begin
                  i_d.st  = I_TX;
                  i_d.oe  = ~rd_data[7];
                  i_d.sr  = {rd_data[6:0], 1'b0};
                  i_d.cnt = 4'h1;
               end
            end
            default: i_d.st = I_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         i_q <= I2C_RESET;
      end else begin
         i_q <= i_d;
      end
   end

   // ----------------------------------------
   // four-wire slave
   // ----------------------------------------
   dsrp_spi_t sp_q;
   dsrp_spi_t sp_d;
   logic [7:0] spi_byte;

   assign spi_byte = {sp_q.sr[6:0], s.sda};

   always_comb begin
      sp_d   = sp_q;
      spi_wr = 1'b0;
      if (!spi_go || s.sel_hi) begin
         // select high resets parser, output level kept
         sp_d      = SPI_RESET;
         sp_d.miso = sp_q.miso;
      end else begin
         if (scl_rise && !(sp_q.nbyte == 2'h2 && !sp_q.rw)) begin
            sp_d.sr  = spi_byte;
            sp_d.cnt = sp_q.cnt + 1'b1;
            if (sp_q.cnt == 3'(BYTE_BITS - 1)) begin
               case (sp_q.nbyte)
                  2'h0: begin
                     sp_d.rw       = spi_byte[RW_BIT];
                     sp_d.ptr[6:0] = spi_byte[6:0];
                     sp_d.nbyte    = 2'h1;
                  end
                  2'h1: begin
                     sp_d.ptr[7] = spi_byte[IDX_HI_BIT];
                     sp_d.nbyte  = 2'h2;
                     sp_d.txc    = '0;
                  end
                  default: begin
                     spi_wr   = 1'b1;
                     sp_d.ptr = sp_q.ptr + 1'b1;
                  end
               endcase
            end
         end
         // msb first, set up on falling edge
         if (scl_fall && sp_q.nbyte == 2'h2 && !sp_q.rw) begin
            sp_d.txc = sp_q.txc + 1'b1;
            if (sp_q.txc == 3'h0) begin
               sp_d.miso = rd_data[7];
               sp_d.tx   = {rd_data[6:0], 1'b0};
            end else begin
               sp_d.miso = sp_q.tx[7];
               sp_d.tx   = {sp_q.tx[6:0], 1'b0};
            end
            if (sp_q.txc == 3'h7) begin
               sp_d.ptr = sp_q.ptr + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         sp_q <= SPI_RESET;
      end else begin
         sp_q <= sp_d;
      end
   end

   // ----------------------------------------
   // shared write port and pins
   // ----------------------------------------
   assign wr_en   = i2c_wr | spi_wr;
   assign wr_addr = det_q.four_wire ? sp_q.ptr : i_q.ptr;
   assign wr_data = det_q.four_wire ? spi_byte : i_q.sr;
   assign rd_addr = det_q.four_wire ? sp_q.ptr : i_q.ptr;

   // no clock output exists, so the clock line is never stretched
   assign sda_pin_out = 1'b0;
   assign sda_pin_oe  = i_q.oe;

   // output driven in four-wire mode regardless of select
   assign address_select_low_bit_out = sp_q.miso;
   assign address_select_low_bit_oe  = spi_go;

   // weak probe only while the pin is being classified
   // relies on nothing else driving the pin here
   assign probe_en    = (det_q.st == D_PROBE_HI) | (det_q.st == D_PROBE_LO);
   assign probe_level = (det_q.st == D_PROBE_HI);

   assign first_interrupt_output = det_q.intr;
   assign four_wire_mode         = det_q.four_wire;
   assign detect_done            = running;

endmodule

`default_nettype wire

//--- bench/dsrp_assertions.sv
`timescale 1ns/100ps
`default_nettype none

module dsrp_assertions #(
   parameter int DETECT_LEN = 40
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // link pins
   input wire logic scl_pin,
   input wire logic address_select_high_bit,
   input wire logic sda_pin_oe,
   input wire logic address_select_low_bit_out,
   input wire logic address_select_low_bit_oe,
   // status
   input wire logic probe_en,
   input wire logic first_interrupt_output,
   input wire logic four_wire_mode,
   input wire logic detect_done
);
   logic        scl_q;
   logic        scl_d;
   logic [3:0]  age_q;
   logic [3:0]  age_d;
   logic [15:0] pcnt_q;
   logic [15:0] pcnt_d;

   // age of the last clock-pin fall, saturating so idle gaps stay harmless
   always_comb begin
      scl_d  = scl_pin;
      age_d  = (age_q == 4'hf) ? age_q : age_q + 4'h1;
      pcnt_d = probe_en ? pcnt_q + 16'h1 : pcnt_q;
      if (scl_q && !scl_pin) begin
         age_d = 4'h0;
      end
      if (rst) begin
         age_d  = 4'hf;
         pcnt_d = 16'h0;
      end
   end

   always_ff @(posedge mclk) begin
      scl_q  <= scl_d;
      age_q  <= age_d;
      pcnt_q <= pcnt_d;
   end

   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (rst);

   sequence s_int_pulse;
      !first_interrupt_output ##1 !first_interrupt_output ##1 first_interrupt_output;
   endsequence

   a_int_pulse: assert property ($fell(probe_en) |-> ##[0:2] s_int_pulse)
      else $error("interrupt pulse after detection is wrong");
   a_int_high: assert property (detect_done |-> first_interrupt_output)
      else $error("interrupt output low after detection");
   a_detect_len: assert property ($fell(probe_en) |->
      int'(pcnt_q) >= DETECT_LEN - 2 && int'(pcnt_q) <= DETECT_LEN + 2)
      else $error("detection window has the wrong length");
   a_probe_off: assert property (detect_done |-> !probe_en)
      else $error("probe still active after detection");
   a_mode_kept: assert property (detect_done && $past(detect_done) |-> $stable(four_wire_mode))
      else $error("interface mode changed without reset");
   a_quiet_early: assert property (!detect_done |-> !sda_pin_oe && !address_select_low_bit_oe)
      else $error("pin driven before detection completed");
   a_slave_only: assert property (four_wire_mode |-> !sda_pin_oe)
      else $error("data pin driven in four-wire mode");
   a_out_driven: assert property (detect_done && four_wire_mode |-> address_select_low_bit_oe)
      else $error("serial output released in four-wire mode");
   a_out_held: assert property (detect_done && four_wire_mode && address_select_high_bit &&
      $past(address_select_high_bit, 3) |-> $stable(address_select_low_bit_out))
      else $error("serial output changed while select was high");
   a_out_on_fall: assert property (detect_done && $changed(address_select_low_bit_out) |->
      age_q inside {[4'h1:4'h7]})
      else $error("serial output changed away from a clock fall");
   a_ack_on_fall: assert property ($changed(sda_pin_oe) |-> age_q inside {[4'h1:4'h7]})
      else $error("data pin drive changed away from a clock fall");
endmodule

`default_nettype wire

//--- bench/dsrp_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module dsrp_host_model (
   // driven by the host
   output var  logic scl,
   output var  logic sda_o,
   output var  logic hi_pin,
   // seen by the host
   input  wire logic sda_w,
   input  wire logic miso
);
   localparam int H = 400;
   event       got;
   logic [7:0] got_val;

   initial begin
      scl    = 1'b1;
      sda_o  = 1'b1;
      hi_pin = 1'b0;
   end

   // odd offset keeps pin changes clear of the sampling clock
   task automatic set_pins(input logic c, input logic d, input logic h);
      #37;
      scl    = c;
      sda_o  = d;
      hi_pin = h;
   endtask

   // ----------------------------------------
   // two-wire master
   // ----------------------------------------
   // start and repeated start
   task automatic i2c_start();
      sda_o = 1'b1;
      #(2*H);
      scl = 1'b1;
      #H;
      sda_o = 1'b0;
      #H;
      scl = 1'b0;
   endtask

   task automatic i2c_stop();
      #100;
      sda_o = 1'b0;
      #300;
      scl = 1'b1;
      #H;
      sda_o = 1'b1;
      #H;
   endtask

   // msb first, ninth bit is the acknowledge
   task automatic i2c_byte(input logic [7:0] v, input logic rd, input logic ab);
      logic [8:0] r;
      for (int i = 8; i >= 0; i--) begin
         #100;
         sda_o = (i > 0) ? v[i-1] : ab;
         #300;
         scl = 1'b1;
         #(H-10);
         r[i] = sda_w;
         #10;
         scl = 1'b0;
      end
      got_val = rd ? r[8:1] : {7'h0, r[0]};
      -> got;
   endtask

   // ----------------------------------------
   // four-wire master
   // ----------------------------------------
   // select held low, msb first, change while clock low
   task automatic spi_bits(input logic [7:0] v, input int n, input logic rd);
      logic [7:0] r;
      r      = 8'h0;
      hi_pin = 1'b0;
      for (int i = 7; i > 7 - n; i--) begin
         sda_o = v[i];
         #H;
         scl = 1'b1;
         #(H-10);
         r[i] = miso;
         #10;
         scl = 1'b0;
      end
      if (rd) begin
         got_val = r;
         -> got;
      end
   endtask

   // select raised once the transaction is done
   task automatic spi_end();
      #H;
      hi_pin = 1'b1;
      #(2*H);
   endtask
endmodule

`default_nettype wire

//--- bench/dual_serial_register_port_tb.sv
`timescale 1ns/100ps
`default_nettype none

module dual_serial_register_port_tb;
   import dsrp_pkg::*;
   localparam int DLEN = 40;
   localparam logic [6:0] ADDRS [4] = '{SLAVE_ADDR_00, SLAVE_ADDR_01, SLAVE_ADDR_10, SLAVE_ADDR_11};
   logic       mclk;
   logic       rst;
   logic       tie_en;
   logic       tie_val;
   wire logic  scl_w;
   wire logic  host_sda;
   wire logic  hi_w;
   wire logic  sda_w;
   wire logic  lo_w;
   wire logic  sda_oe;
   wire logic  sda_out;
   wire logic  lo_out;
   wire logic  lo_oe;
   wire logic  probe_level;
   wire logic  probe_en;
   wire logic  int_o;
   wire logic  fw_mode;
   wire logic  done;
   logic [7:0] dat [8];
   logic [7:0] idx;
   logic [7:0] qe [$];
   string      qn [$];
   int         n_errors;
   int         checks;
   int         cyc;

   // open-drain data with pull-up; floating select pin follows the probe
   assign sda_w = host_sda & (sda_oe ? sda_out : 1'b1);
   assign lo_w  = lo_oe ? lo_out : (tie_en ? tie_val : probe_level);

   dsrp_top #(.DETECT_LEN(DLEN)) dut (
      .mclk(mclk), .rst(rst), .scl_pin(scl_w), .sda_pin_in(sda_w), .sda_pin_out(sda_out), .sda_pin_oe(sda_oe),
      .address_select_high_bit(hi_w), .address_select_low_bit_in(lo_w), .address_select_low_bit_out(lo_out),
      .address_select_low_bit_oe(lo_oe), .probe_level(probe_level), .probe_en(probe_en),
      .first_interrupt_output(int_o), .four_wire_mode(fw_mode), .detect_done(done));

   dsrp_host_model host (.scl(scl_w), .sda_o(host_sda), .hi_pin(hi_w), .sda_w(sda_w), .miso(lo_w));

   initial mclk = 1'b0;
   always #50 mclk = ~mclk;

   task automatic note(input string n, input logic [7:0] v);
      qn.push_back(n);
      qe.push_back(v);
   endtask

   task automatic chk(input logic [7:0] seen);
      logic [7:0] e;
      string      n;
      checks++;
      if (qe.size() == 0) begin
         n_errors++;
         $display("wrong value unexpected result expected none seen %h", seen);
      end else begin
         e = qe.pop_front();
         n = qn.pop_front();
         if (seen !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", n, e, seen);
         end
      end
   endtask

   always @(host.got) chk(host.got_val);
   always @(posedge done) begin
      #1;
      chk({7'h0, fw_mode});
   end

   task automatic report_and_stop();
      if (qe.size() != 0) n_errors++;
      if (n_errors == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         report_and_stop();
      end
   end

   task automatic do_reset(input logic [7:0] m);
      note("interface mode", m);
      @(posedge mclk);
      rst <= 1'b1;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      for (int i = 0; i < 200 && done !== 1'b1; i++) @(posedge mclk);
      repeat (2) @(posedge mclk);
   endtask

   task automatic i2c_write(input logic [6:0] a, input int o, input int n, input logic ok, input logic fin);
      note("address ack", {7'h0, !ok});
      host.i2c_start();
      host.i2c_byte({a, 1'b0}, 1'b0, 1'b1);
      if (ok) begin
         note("index ack", 8'h0);
         host.i2c_byte(idx + 8'(o), 1'b0, 1'b1);
         for (int i = o; i < o + n; i++) begin
            note("data ack", 8'h0);
            host.i2c_byte(dat[i], 1'b0, 1'b1);
         end
      end
      if (fin) host.i2c_stop();
   endtask

   task automatic i2c_read(input logic [6:0] a, input int n);
      i2c_write(a, 0, 0, 1'b1, 1'b0);
      note("read address ack", 8'h0);
      host.i2c_start();
      host.i2c_byte({a, 1'b1}, 1'b0, 1'b1);
      for (int i = 0; i < n; i++) begin
         note("read byte", dat[i]);
         host.i2c_byte(8'hff, 1'b1, i == n - 1);
      end
      host.i2c_stop();
   endtask

   task automatic spi_frame(input logic rw, input logic [7:0] ix, input int n);
      host.spi_bits({rw, ix[6:0]}, 8, 1'b0);
      host.spi_bits({ix[7], 7'($urandom)}, 8, 1'b0);
      for (int i = 0; i < n; i++) begin
         if (!rw) note("serial read byte", dat[i]);
         host.spi_bits(rw ? dat[i] : 8'($urandom), 8, !rw);
      end
   endtask

   initial begin
      void'($urandom(32'h4228));
      rst      = 1'b1;
      tie_en   = 1'b1;
      tie_val  = 1'b1;
      n_errors = 0;
      checks   = 0;
      cyc      = 0;
      idx      = 8'h80 | 8'($urandom_range(0, 100));
      foreach (dat[i]) dat[i] = 8'($urandom);
      do_reset(8'h0);
      for (int a = 0; a < 4; a++) begin
         @(posedge mclk);
         tie_val <= a[0];
         host.set_pins(1'b1, 1'b1, a[1]);
         i2c_write(ADDRS[a] ^ 7'h01, 4, 1, 1'b0, 1'b1);
         i2c_write(ADDRS[a], 4, 1, 1'b1, 1'b1);
      end
      i2c_write(ADDRS[3], 0, 4, 1'b1, 1'b1);
      i2c_read(ADDRS[3], 5);
      // pin left floating for the second detection
      @(posedge mclk);
      tie_en <= 1'b0;
      host.set_pins(1'b0, 1'b0, 1'b1);
      foreach (dat[i]) dat[i] = 8'($urandom);
      do_reset(8'h1);
      host.set_pins(1'b0, 1'b0, 1'b1);
      spi_frame(1'b1, idx, 4);
      host.spi_end();
      spi_frame(1'b1, idx + 8'h1, 0);
      host.spi_bits(~dat[1], 5, 1'b0);
      host.spi_end();
      spi_frame(1'b0, idx, 4);
      host.spi_end();
      report_and_stop();
   end
endmodule

bind dsrp_top dsrp_assertions #(.DETECT_LEN(DETECT_LEN)) u_chk (
   .mclk(mclk), .rst(rst), .scl_pin(scl_pin), .sda_pin_oe(sda_pin_oe),
   .address_select_high_bit(address_select_high_bit),
   .address_select_low_bit_out(address_select_low_bit_out),
   .address_select_low_bit_oe(address_select_low_bit_oe), .probe_en(probe_en),
   .first_interrupt_output(first_interrupt_output), .four_wire_mode(four_wire_mode),
   .detect_done(detect_done));

`default_nettype wire
